//--- lmc_far_side.sv
// Far side of the block: contact wiring with selectable polarity, and a load
// bank that follows the multi-step pulses. Assumes one-hot pulses on clk.
`timescale 1ns/10ps
module lmc_far_side (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] act,
    input wire logic [2:0] nc,
    input wire logic [4:0] m_add,
    input wire logic [4:0] m_sub,
    output lmc_pkg::lmc_contacts_s raw,
    output logic [2:0] bank_n
);
    logic [4:0] add_q;
    logic [4:0] sub_q;
    // A normally-closed contact opens when its signal is present
    assign raw = act ^ nc;
    // Count on pulse starts only, so a long pulse moves the bank by one step
    always_ff @(posedge clk) begin
        add_q <= m_add;
        sub_q <= m_sub;
        if (sys_rst) begin
            bank_n <= 3'h0;
        end else if ((m_add & ~add_q) != 5'h00) begin
            bank_n <= bank_n + 3'h1;
        end else if ((m_sub & ~sub_q) != 5'h00) begin
            bank_n <= bank_n - 3'h1;
        end
    end
endmodule

//--- lmc_pkg.sv
// Constants, field layout and state carriers for the load management controller.
// Assumes one 200 MHz clock; power words arrive already scaled and synchronous.
package lmc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 18;
    localparam int unsigned PULSE_MS = 250;
    localparam logic [7:0] PULSE_TICKS = 8'(PULSE_MS * 1000000 / TICK_NS);
    localparam int unsigned NUM_STEPS = 5;
    localparam logic [1:0] ALARM_NONE = 2'h3;

    // Register indices on the plain register port
    localparam logic [3:0] REG_SHED_HI = 4'h0;
    localparam logic [3:0] REG_SHED_LO = 4'h1;
    localparam logic [3:0] REG_REPEAT = 4'h2;
    localparam logic [3:0] REG_CROSS = 4'h3;
    localparam logic [3:0] REG_M_ADD_LVL = 4'h4;
    localparam logic [3:0] REG_M_SUB_LVL = 4'h5;
    localparam logic [3:0] REG_M_ADD_SD = 4'h6;
    localparam logic [3:0] REG_M_ADD_WD = 4'h7;
    localparam logic [3:0] REG_M_SUB_SD = 4'h8;
    localparam logic [3:0] REG_M_SUB_WD = 4'h9;
    localparam logic [3:0] REG_IN_CFG = 4'ha;
    localparam logic [3:0] REG_ALARM = 4'hb;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // Input configuration bit positions
    localparam int unsigned CFG_RS_DEF = 0;
    localparam int unsigned CFG_RS_NC = 1;
    localparam int unsigned CFG_DAS_DEF = 2;
    localparam int unsigned CFG_DAS_NC = 3;
    localparam int unsigned CFG_FS_DEF = 4;
    localparam int unsigned CFG_FS_NC = 5;

    // Reset values, in power units and milliseconds
    localparam logic [15:0] RST_SHED_HI = 16'hffff;
    localparam logic [15:0] RST_SHED_LO = 16'h0000;
    localparam logic [15:0] RST_DELAY = 16'h03e8;
    localparam logic [15:0] RST_M_ADD_LVL = 16'h0000;
    localparam logic [15:0] RST_M_SUB_LVL = 16'hffff;
    localparam logic [7:0] RST_IN_CFG = 8'h00;
    localparam logic [1:0] RST_ALARM = 2'h0;

    typedef enum logic [1:0] {
        M_IDLE,
        M_ADD,
        M_SUB
    } lmc_mode_e;

    // Raw contact levels as seen at the pins
    typedef struct packed {
        logic remote_start;
        logic disable_start;
        logic force_start;
    } lmc_contacts_s;

    // Whole block state, registered in one place
    typedef struct packed {
        logic [15:0] shed_hi;
        logic [15:0] shed_lo;
        logic [15:0] rep_dly;
        logic [15:0] cross_dly;
        logic [15:0] m_add_lvl;
        logic [15:0] m_sub_lvl;
        logic [15:0] m_add_sd;
        logic [15:0] m_add_wd;
        logic [15:0] m_sub_sd;
        logic [15:0] m_sub_wd;
        logic [7:0] in_cfg;
        logic [1:0] alarm_a;
        logic [DIV_W-1:0] div;
        logic tick;
        logic shed;
        logic add;
        logic sub;
        logic [15:0] since_add;
        logic [15:0] since_sub;
        logic [2:0] steps;
        logic [15:0] qual_add;
        logic [15:0] qual_sub;
        logic [15:0] wait_add;
        logic [15:0] wait_sub;
        lmc_mode_e mode;
        logic [7:0] pcnt;
        logic [2:0] pidx;
        logic [15:0] rdata;
    } lmc_state_s;
endpackage

//--- lmc_top.sv
// Load shedding, paced single-step add/subtract, five-step load manager and
// remote-start / disable-start contact interpretation.
// Assumes power_i and contacts are synchronous to clk; registers sit on a
// plain port with read data one cycle after the read strobe.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module lmc_top #(
    parameter int unsigned TICK_CYCLES = lmc_pkg::TICK_CYCLES,
    parameter int unsigned NSTEP = lmc_pkg::NUM_STEPS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] power_i,
    input wire logic mains_ok_meas,
    input wire lmc_pkg::lmc_contacts_s contacts_i,
    output logic shed_o,
    output logic dummy_o,
    output logic add_o,
    output logic sub_o,
    output logic [NSTEP-1:0] multi_add_o,
    output logic [NSTEP-1:0] multi_sub_o,
    output logic [NSTEP-1:0] step_on_o,
    output logic mains_ok_o,
    output logic mains_lamp_o,
    output logic force_start_o,
    output logic input_alarm_o
);
    // Elaboration-time limits of the counters
    if (NSTEP < 1 || NSTEP > 7) begin : g_bad_nstep
        $error("NSTEP must be 1 to 7");
    end
    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << lmc_pkg::DIV_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range of the divider");
    end

    localparam logic [lmc_pkg::DIV_W-1:0] DIV_LAST = lmc_pkg::DIV_W'(TICK_CYCLES - 1);
    localparam logic [2:0] STEP_MAX = 3'(NSTEP);

    lmc_pkg::lmc_state_s st_q;
    lmc_pkg::lmc_state_s st_d;
    logic rs_act;
    logic das_act;
    logic fs_act;
    logic rs_def;
    logic below_lo;
    logic above_hi;
    logic below_madd;
    logic above_msub;

    // Saturating millisecond counter step, shared by every delay timer
    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic t);
        sat_inc = (t && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction

    // Contact polarity: NC contacts read inverted before use
    function automatic logic contact_active(input logic raw, input logic nc, input logic def);
        contact_active = def & (raw ^ nc);
    endfunction

    // One-hot step select for the pulse outputs
    function automatic logic [NSTEP-1:0] step_sel(input logic [2:0] idx);
        step_sel = '0;
        for (int i = 0; i < NSTEP; i++) begin
            if (idx == 3'(i)) begin
                step_sel[i] = 1'b1;
            end
        end
    endfunction

    // Contact interpretation
    assign rs_def = st_q.in_cfg[lmc_pkg::CFG_RS_DEF];
    assign rs_act = contact_active(contacts_i.remote_start, st_q.in_cfg[lmc_pkg::CFG_RS_NC],
        rs_def);
    assign das_act = contact_active(contacts_i.disable_start,
        st_q.in_cfg[lmc_pkg::CFG_DAS_NC], st_q.in_cfg[lmc_pkg::CFG_DAS_DEF]);
    assign fs_act = contact_active(contacts_i.force_start, st_q.in_cfg[lmc_pkg::CFG_FS_NC],
        st_q.in_cfg[lmc_pkg::CFG_FS_DEF]);

    // Threshold comparisons against the configured levels
    assign below_lo = power_i < st_q.shed_lo;
    assign above_hi = power_i > st_q.shed_hi;
    assign below_madd = power_i < st_q.m_add_lvl;
    assign above_msub = power_i > st_q.m_sub_lvl;

    // Next-state logic for the whole block
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;

        // Common 1 ms time base
        if (st_q.div == DIV_LAST) begin
            st_d.div = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.div = st_q.div + 1'b1;
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                lmc_pkg::REG_SHED_HI: st_d.shed_hi = reg_wdata;
                lmc_pkg::REG_SHED_LO: st_d.shed_lo = reg_wdata;
                lmc_pkg::REG_REPEAT: st_d.rep_dly = reg_wdata;
                lmc_pkg::REG_CROSS: st_d.cross_dly = reg_wdata;
                lmc_pkg::REG_M_ADD_LVL: st_d.m_add_lvl = reg_wdata;
                lmc_pkg::REG_M_SUB_LVL: st_d.m_sub_lvl = reg_wdata;
                lmc_pkg::REG_M_ADD_SD: st_d.m_add_sd = reg_wdata;
                lmc_pkg::REG_M_ADD_WD: st_d.m_add_wd = reg_wdata;
                lmc_pkg::REG_M_SUB_SD: st_d.m_sub_sd = reg_wdata;
                lmc_pkg::REG_M_SUB_WD: st_d.m_sub_wd = reg_wdata;
                lmc_pkg::REG_IN_CFG: st_d.in_cfg = reg_wdata[7:0];
                lmc_pkg::REG_ALARM: st_d.alarm_a = reg_wdata[1:0];
                default: ;
            endcase
        end
        // Remote-start input is pinned to the no-alarm input_alarm_a
        if (st_d.in_cfg[lmc_pkg::CFG_RS_DEF]) begin
            st_d.alarm_a = lmc_pkg::ALARM_NONE;
        end

        // Register reads, answered one cycle later; unmapped reads give zero
        if (reg_rd) begin
            case (reg_addr)
                lmc_pkg::REG_SHED_HI: st_d.rdata = st_q.shed_hi;
                lmc_pkg::REG_SHED_LO: st_d.rdata = st_q.shed_lo;
                lmc_pkg::REG_REPEAT: st_d.rdata = st_q.rep_dly;
                lmc_pkg::REG_CROSS: st_d.rdata = st_q.cross_dly;
                lmc_pkg::REG_M_ADD_LVL: st_d.rdata = st_q.m_add_lvl;
                lmc_pkg::REG_M_SUB_LVL: st_d.rdata = st_q.m_sub_lvl;
                lmc_pkg::REG_M_ADD_SD: st_d.rdata = st_q.m_add_sd;
                lmc_pkg::REG_M_ADD_WD: st_d.rdata = st_q.m_add_wd;
                lmc_pkg::REG_M_SUB_SD: st_d.rdata = st_q.m_sub_sd;
                lmc_pkg::REG_M_SUB_WD: st_d.rdata = st_q.m_sub_wd;
                lmc_pkg::REG_IN_CFG: st_d.rdata = {8'h00, st_q.in_cfg};
                lmc_pkg::REG_ALARM: st_d.rdata = {14'h0000, st_q.alarm_a};
                lmc_pkg::REG_STATUS: st_d.rdata = {7'h00, st_q.mode != lmc_pkg::M_IDLE,
                    st_q.steps, mains_lamp_o, mains_ok_o, st_q.sub, st_q.add, st_q.shed};
                default: st_d.rdata = 16'h0000;
            endcase
        end else begin
            st_d.rdata = 16'h0000;
        end

        // Shed hysteresis; no enable bit exists, it always runs
        if (above_hi) begin
            st_d.shed = 1'b1;
        end else if (below_lo) begin
            st_d.shed = 1'b0;
        end

        // Gap counters run while the output is idle, so they time from pulse end
        st_d.since_add = st_q.add ? 16'h0000 : sat_inc(st_q.since_add, st_q.tick);
        st_d.since_sub = st_q.sub ? 16'h0000 : sat_inc(st_q.since_sub, st_q.tick);

        // Step add: held off by repeat and crossover gaps, then rechecked
        if (st_q.add) begin
            st_d.add = below_lo;
        end else if (below_lo && !st_q.sub && st_q.since_add >= st_q.rep_dly &&
                     st_q.since_sub >= st_q.cross_dly) begin
            st_d.add = 1'b1;
        end

        // Step subtract, mirror of the add path
        if (st_q.sub) begin
            st_d.sub = above_hi;
        end else if (above_hi && !st_q.add && st_q.since_sub >= st_q.rep_dly &&
                     st_q.since_add >= st_q.cross_dly) begin
            st_d.sub = 1'b1;
        end

        // Qualifying timers restart as soon as their condition drops
        st_d.qual_add = below_madd ? sat_inc(st_q.qual_add, st_q.tick) : 16'h0000;
        st_d.qual_sub = above_msub ? sat_inc(st_q.qual_sub, st_q.tick) : 16'h0000;
        st_d.wait_add = sat_inc(st_q.wait_add, st_q.tick);
        st_d.wait_sub = sat_inc(st_q.wait_sub, st_q.tick);

        // Five-step manager: one pulse at a time
        case (st_q.mode)
            lmc_pkg::M_IDLE: begin
                if (st_q.qual_add >= st_q.m_add_sd && st_q.wait_add >= st_q.m_add_wd &&
                    st_q.steps < STEP_MAX) begin
                    // Connect the next step upward
                    st_d.mode = lmc_pkg::M_ADD;
                    st_d.pidx = st_q.steps;
                    st_d.steps = st_q.steps + 3'h1;
                    st_d.qual_add = 16'h0000;
                    st_d.wait_add = 16'h0000;
                    st_d.pcnt = 8'h00;
                end else if (st_q.qual_sub >= st_q.m_sub_sd && st_q.wait_sub >= st_q.m_sub_wd &&
                             st_q.steps != 3'h0) begin
                    // Remove the highest connected step
                    st_d.mode = lmc_pkg::M_SUB;
                    st_d.pidx = st_q.steps - 3'h1;
                    st_d.steps = st_q.steps - 3'h1;
                    st_d.qual_sub = 16'h0000;
                    st_d.wait_sub = 16'h0000;
                    st_d.pcnt = 8'h00;
                end
            end
            lmc_pkg::M_ADD, lmc_pkg::M_SUB: begin
                // Fixed-width pulse counted in ticks
                if (st_q.tick) begin
                    if (st_q.pcnt == lmc_pkg::PULSE_TICKS - 8'h01) begin
                        st_d.mode = lmc_pkg::M_IDLE;
                        st_d.pcnt = 8'h00;
                    end else begin
                        st_d.pcnt = st_q.pcnt + 8'h01;
                    end
                end
            end
            default: st_d.mode = lmc_pkg::M_IDLE;
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.shed_hi <= lmc_pkg::RST_SHED_HI;
            st_q.shed_lo <= lmc_pkg::RST_SHED_LO;
            st_q.rep_dly <= lmc_pkg::RST_DELAY;
            st_q.cross_dly <= lmc_pkg::RST_DELAY;
            st_q.m_add_lvl <= lmc_pkg::RST_M_ADD_LVL;
            st_q.m_sub_lvl <= lmc_pkg::RST_M_SUB_LVL;
            st_q.m_add_sd <= lmc_pkg::RST_DELAY;
            st_q.m_add_wd <= lmc_pkg::RST_DELAY;
            st_q.m_sub_sd <= lmc_pkg::RST_DELAY;
            st_q.m_sub_wd <= lmc_pkg::RST_DELAY;
            st_q.in_cfg <= lmc_pkg::RST_IN_CFG;
            st_q.alarm_a <= lmc_pkg::RST_ALARM;
            st_q.mode <= lmc_pkg::M_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Output drive
    assign reg_rdata = st_q.rdata;
    assign shed_o = st_q.shed;
    assign dummy_o = ~st_q.shed;
    assign add_o = st_q.add;
    assign sub_o = st_q.sub;
    assign multi_add_o = (st_q.mode == lmc_pkg::M_ADD) ? step_sel(st_q.pidx) : '0;
    assign multi_sub_o = (st_q.mode == lmc_pkg::M_SUB) ? step_sel(st_q.pidx) : '0;

    // Step outputs with an index below the count are connected
    genvar gi;
    generate
        for (gi = 0; gi < NSTEP; gi++) begin : g_step
            assign step_on_o[gi] = st_q.steps > 3'(gi);
        end
    endgenerate

    // Mains interpretation: remote start wins over everything
    // A running engine is not stopped here; the sequencer sees healthy mains and
    // runs its usual mains-wait and cooldown, then real status returns
    always_comb begin
        if (rs_def) begin
            mains_ok_o = ~rs_act;
            mains_lamp_o = ~rs_act;
        end else if (das_act) begin
            mains_ok_o = 1'b1;
            mains_lamp_o = 1'b1;
        end else begin
            mains_ok_o = mains_ok_meas;
            mains_lamp_o = mains_ok_meas;
        end
    end
    assign force_start_o = fs_act & ~rs_act;
    // Alarm from the remote-start input only while its input_alarm_a is not 3
    assign input_alarm_o = rs_act & (st_q.alarm_a != lmc_pkg::ALARM_NONE);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_pulse_start;
        st_q.mode == lmc_pkg::M_IDLE ##1 st_q.mode != lmc_pkg::M_IDLE;
    endsequence

    // End of a multi-step pulse: busy one cycle, idle the next
    sequence s_pulse_end;
        st_q.mode != lmc_pkg::M_IDLE ##1 st_q.mode == lmc_pkg::M_IDLE;
    endsequence

    a_shed_set: assert property (above_hi |=> shed_o)
        else $error("shed output not set above upper threshold");
    a_shed_clear: assert property (below_lo && !above_hi |=> !shed_o)
        else $error("shed output not released below lower threshold");
    a_shed_hold: assert property (!below_lo && !above_hi |=> $stable(shed_o))
        else $error("shed output moved between thresholds");
    a_dummy_inv: assert property (dummy_o != shed_o)
        else $error("dummy output not inverse of shed");
    a_add_drop: assert property (add_o && !below_lo |=> !add_o)
        else $error("step add kept above lower threshold");
    a_sub_drop: assert property (sub_o && !above_hi |=> !sub_o)
        else $error("step subtract kept below upper threshold");
    a_add_repeat: assert property ($rose(add_o) |-> $past(st_q.since_add) >= $past(st_q.rep_dly)
        && $past(below_lo))
        else $error("step add before repeat delay");
    a_add_cross: assert property ($rose(add_o) |-> $past(st_q.since_sub) >= $past(st_q.cross_dly))
        else $error("step add before crossover delay");
    a_sub_cross: assert property ($rose(sub_o) |-> $past(st_q.since_add) >= $past(st_q.cross_dly))
        else $error("step subtract before crossover delay");
    a_step_count: assert property (s_pulse_start |-> (st_q.mode == lmc_pkg::M_ADD) ?
        st_q.steps == $past(st_q.steps) + 3'h1 : st_q.steps == $past(st_q.steps) - 3'h1)
        else $error("step count not moved by exactly one");
    a_add_qual: assert property ($rose(|multi_add_o) |-> $past(st_q.qual_add) >= $past(st_q.m_add_sd)
        && $past(st_q.wait_add) >= $past(st_q.m_add_wd))
        else $error("multi add before start or wait delay");
    a_pulse_len: assert property (st_q.mode != lmc_pkg::M_IDLE |-> st_q.pcnt < lmc_pkg::PULSE_TICKS)
        else $error("multi step pulse too long");
    a_remote_mains: assert property (rs_def |-> mains_ok_o == !rs_act && mains_lamp_o == !rs_act)
        else $error("mains view does not follow remote start");
    a_das_mains: assert property (!rs_def && das_act |-> mains_ok_o && mains_lamp_o)
        else $error("disable start did not report mains present");

    // Subtract side of the repeat spacing
    a_sub_repeat: assert property ($rose(sub_o) |-> $past(st_q.since_sub) >= $past(st_q.rep_dly)
        && $past(above_hi))
        else $error("step subtract before repeat delay");
    // Add and subtract never overlap, the crossover gap sits between them
    a_add_sub_excl: assert property (!(add_o && sub_o))
        else $error("step add and subtract active together");
    // Multi subtract qualified by its start and wait timers
    a_sub_qual: assert property ($rose(|multi_sub_o) |-> $past(st_q.qual_sub) >= $past(st_q.m_sub_sd)
        && $past(st_q.wait_sub) >= $past(st_q.m_sub_wd))
        else $error("multi subtract before start or wait delay");
    // Only one step pulse line at a time
    a_multi_onehot: assert property ($onehot0(multi_add_o | multi_sub_o))
        else $error("more than one multi step pulse");
    // A pulsed add names a step that is now connected
    a_add_target: assert property (|multi_add_o |-> (multi_add_o & ~step_on_o) == '0)
        else $error("multi add names an unconnected step");
    // A pulsed subtract names a step that is now released
    a_sub_target: assert property (|multi_sub_o |-> (multi_sub_o & step_on_o) == '0)
        else $error("multi subtract names a connected step");
    // Step count never passes the number of outputs
    a_step_limit: assert property (st_q.steps <= STEP_MAX)
        else $error("step count beyond limit");
    // A pulse always runs its full length before ending
    a_pulse_full: assert property (s_pulse_end |-> $past(st_q.pcnt) == lmc_pkg::PULSE_TICKS - 8'h01)
        else $error("multi step pulse ended early");
    // Remote start blocks forced start
    a_force_block: assert property (rs_act |-> !force_start_o)
        else $error("forced start while remote start active");
    // Remote-start input keeps the no-alarm input_alarm_a and never alarms
    a_alarm_code: assert property (rs_def |-> st_q.alarm_a == lmc_pkg::ALARM_NONE)
        else $error("remote start input input_alarm_a not 3");
    a_alarm_quiet: assert property (rs_def |-> !input_alarm_o)
        else $error("remote start input raised an alarm");
    // Without overrides the measured mains comes through untouched
    a_mains_meas: assert property (!rs_def && !das_act |-> mains_ok_o == mains_ok_meas)
        else $error("measured mains not restored");
    // Time base pulses last one cycle
    a_tick_pulse: assert property (st_q.tick |=> !st_q.tick)
        else $error("time base tick longer than one cycle");
    // Add qualifier restarts when power leaves the add level
    a_qual_restart: assert property (!below_madd |=> st_q.qual_add == 16'h0000)
        else $error("add qualifier not restarted");
endmodule

//--- load_management_controller_bench.sv
// Bench: contact table, reset values, shed hysteresis, crossover hold-off, steps.
// Assumes a shortened tick of 10 clocks, so one delay unit is 50 ns.
`timescale 1ns/10ps
module load_management_controller_bench;
    localparam int TC = 10;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] power_i = 16'h0040;
    logic mains_ok_meas = 1'b0;
    logic [2:0] act = 3'h0;
    logic [5:0] cfg = 6'h00;
    lmc_pkg::lmc_contacts_s raw;
    logic shed_o, dummy_o, add_o, sub_o, mains_ok_o, mains_lamp_o, force_start_o, input_alarm_o;
    logic [4:0] m_add, m_sub, step_on;
    logic [2:0] bank_n;
    int n_errors = 0;
    int n_tests = 0;
    int gap, len;
    // Row: config, requested contacts, measured mains, mains ok, forced start
    logic [11:0] rows [10] = '{12'h000, 12'h064, 12'h042, 12'h0e4, 12'h112,
        12'h300, 12'h312, 12'h174, 12'h40f, 12'h468};
    // Register index and its value after reset; 4'hd is unmapped, 4'hc is idle status
    logic [19:0] regv [8] = '{20'h0ffff, 20'h10000, 20'h203e8, 20'h903e8,
        20'ha0000, 20'hb0000, 20'hd0000, 20'hc0000};
    // Delays in ticks: repeat 2, crossover 40, start 10, wait 3
    logic [19:0] setv [8] = '{20'h00064, 20'h10032, 20'h20002, 20'h30028,
        20'h6000a, 20'h70003, 20'h8000a, 20'h90003};

    lmc_top #(.TICK_CYCLES(TC), .NSTEP(5)) dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_i(power_i), .mains_ok_meas(mains_ok_meas),
        .contacts_i(raw), .shed_o(shed_o), .dummy_o(dummy_o), .add_o(add_o),
        .sub_o(sub_o), .multi_add_o(m_add), .multi_sub_o(m_sub), .step_on_o(step_on),
        .mains_ok_o(mains_ok_o), .mains_lamp_o(mains_lamp_o),
        .force_start_o(force_start_o), .input_alarm_o(input_alarm_o));
    lmc_far_side far (.clk(clk), .sys_rst(sys_rst), .act(act),
        .nc({cfg[1], cfg[3], cfg[5]}), .m_add(m_add), .m_sub(m_sub), .raw(raw),
        .bank_n(bank_n));

    // Free-running clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task conclude;
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task rst(input int n);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (n) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // Strobes last one cycle; the task idles a cycle so strobes never double up
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task pw(input logic [15:0] v, input int n);
        @(posedge clk);
        power_i <= v;
        repeat (n) @(negedge clk);
    endtask

    // Waits for one multi-step pulse, then checks its step, start and length
    // Later pulses follow at once: start and wait delays already ran during the last pulse
    task mp(input logic up, input logic [4:0] exp, input int g0);
        for (gap = 0; (up ? m_add : m_sub) === 5'h00 && gap < 4000; gap++) @(negedge clk);
        chk(16'(up ? m_add : m_sub), 16'(exp));
        chk(16'(gap >= g0 && gap <= g0 + 30), 16'h0001);
        for (len = 0; (up ? m_add : m_sub) !== 5'h00 && len < 4000; len++) @(negedge clk);
        chk(16'(len >= 2490 && len <= 2510), 16'h0001);
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #300000;
        n_errors++;
        conclude;
    end

    initial begin
        rst(12);
        for (int i = 0; i < 10; i++) begin
            wr(lmc_pkg::REG_IN_CFG, {10'h000, rows[i][11:6]});
            cfg <= rows[i][11:6];
            act <= rows[i][5:3];
            mains_ok_meas <= rows[i][2];
            @(negedge clk);
            chk(16'(mains_ok_o), 16'(rows[i][1]));
            chk(16'(mains_lamp_o), 16'(rows[i][1]));
            chk(16'(force_start_o), 16'(rows[i][0]));
            if (cfg[0]) begin
                rd(lmc_pkg::REG_ALARM, 16'h0003);
                chk(16'(input_alarm_o), 16'h0000);
            end
        end
        // Mid-run reset, then reset values and an unmapped write and read
        rst(2);
        @(negedge clk);
        chk(16'({shed_o, dummy_o, step_on}), 16'h0020);
        wr(4'hd, 16'h1234);
        for (int i = 0; i < 8; i++) rd(regv[i][19:16], regv[i][15:0]);
        for (int i = 0; i < 8; i++) wr(setv[i][19:16], setv[i][15:0]);
        // Shed hysteresis and single-step add/subtract pacing
        pw(16'h0078, 450);
        chk(16'({shed_o, dummy_o, sub_o}), 16'h0005);
        pw(16'h0050, 80);
        chk(16'({shed_o, sub_o}), 16'h0002);
        pw(16'h001e, 20);
        chk(16'({shed_o, dummy_o, add_o}), 16'h0002);
        for (gap = 0; add_o !== 1'b1 && gap < 400; gap++) @(negedge clk);
        chk(16'(gap >= 270 && gap <= 320), 16'h0001);
        pw(16'h0050, 10);
        chk(16'(add_o), 16'h0000);
        pw(16'h001e, 2);
        chk(16'(add_o), 16'h0000);
        for (gap = 0; add_o !== 1'b1 && gap < 40; gap++) @(negedge clk);
        chk(16'(add_o), 16'h0001);
        // Five-step manager: fill, refuse a sixth, then empty from the top
        pw(16'h0040, 2);
        wr(lmc_pkg::REG_M_SUB_LVL, 16'h03e8);
        wr(lmc_pkg::REG_M_ADD_LVL, 16'h00c8);
        for (int k = 0; k < 5; k++) mp(1'b1, 5'h01 << k, (k == 0) ? 90 : 0);
        for (len = 0; m_add === 5'h00 && len < 400; len++) @(negedge clk);
        chk(16'({m_add, step_on, bank_n}), 16'h00fd);
        pw(16'h07d0, 0);
        for (int k = 4; k >= 0; k--) mp(1'b0, 5'h01 << k, (k == 4) ? 90 : 0);
        chk(16'({step_on, bank_n}), 16'h0000);
        conclude;
    end
endmodule
